/* design/dopc_pkg.sv */
// Package of constants and types for the data operation circuit.
// Behaviour
// - Compare, add or subtract sixteen-bit operands by mode.
// - Interrupt request only when selected condition holds.
// - Compare raises on match or mismatch, configurable.
// - Addition raises on carry beyond 0xffff.
// - Subtraction raises on borrow below zero.
// - Subtraction underflow sets result flag to one.
// - Mode encoding 10b selects subtraction.
package dopc_pkg;
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_REF      = 12'h004;
    localparam logic [11:0] ADDR_INPUT    = 12'h008;
    localparam logic [11:0] ADDR_STATUS   = 12'h00c;
    localparam int          CTRL_MODE_LSB = 0;
    localparam int          CTRL_MISM_BIT = 2;
    localparam int          CTRL_CLR_BIT  = 3;
    localparam logic [1:0]  MODE_RESET    = 2'h0;
    localparam logic [15:0] REF_RESET     = 16'h0000;
    localparam logic [15:0] INPUT_RESET   = 16'h0000;

    // Operating mode; code 3 is illegal and never raises the flag.
    typedef enum logic [1:0] {
        DOPC_MODE_CMP = 2'b00,
        DOPC_MODE_ADD = 2'b01,
        DOPC_MODE_SUB = 2'b10
    } dopc_mode_t;
endpackage : dopc_pkg

/* design/dopc_alu.sv */
// Sixteen-bit arithmetic core of the data operation circuit.
`timescale 1ns/1ps
module dopc_alu (
    input  wire logic [1:0]  mode,
    input  wire logic        mism_sel,
    input  wire logic [15:0] ref_val,
    input  wire logic [15:0] in_val,
    output logic             cond,
    output logic [15:0]      result
);
    logic [16:0] sum_w;
    logic [16:0] dif_w;

    // One adder and one subtractor; the seventeenth bit is carry or borrow.
    always_comb begin
        sum_w  = {1'b0, ref_val} + {1'b0, in_val};
        dif_w  = {1'b0, ref_val} - {1'b0, in_val};
        cond   = 1'b0;
        result = ref_val;
        case (mode)
            dopc_pkg::DOPC_MODE_CMP: begin
                cond = mism_sel ? (ref_val != in_val) : (ref_val == in_val);
            end
            dopc_pkg::DOPC_MODE_ADD: begin
                cond   = sum_w[16];
                result = sum_w[15:0];
            end
            dopc_pkg::DOPC_MODE_SUB: begin
                cond   = dif_w[16];
                result = dif_w[15:0];
            end
            default: begin
                cond   = 1'b0;
                result = ref_val;
            end
        endcase
    end
endmodule : dopc_alu

/* design/dopc_top.sv */
// APB-attached data operation circuit with sticky result flag and request.
`timescale 1ns/1ps
module dopc_top (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             op_irq
);
    // Register map, one aligned word each, data in bits 15:0:
    //   control   - mode in bits 1:0 (compare, add, subtract), bit 2 selects raising
    //               on a mismatch instead of a match, bit 3 clears the result flag
    //               when written with one and always reads back as zero.
    //   reference - threshold or running value; add and subtract write back here.
    //   input     - each write runs the selected operation on the new sample.
    //   status    - bit 0 is the sticky result flag, read only.
    // Mode code 3 is accepted and read back; an input write only stores the sample, so software that
    // writes it by mistake never sees a false level-judgement event.
    // The whole state lives in one packed struct so that reset and next-state
    // handling cover every field without a chance of one being forgotten.
    typedef struct packed {
        logic [1:0]  mode;
        logic        mism;
        logic [15:0] ref_val;
        logic [15:0] in_val;
        logic        flag;
        logic        irq;
        logic        ready;
        logic        slverr;
        logic [31:0] rdata;
    } dopc_state_t;

    dopc_state_t state_ff;
    dopc_state_t nxt_state;
    logic        alu_cond;
    logic [15:0] alu_result;
    logic        setup_w;
    logic        wr_w;
    logic        in_wr_w;

    // Operation is evaluated on the incoming write data, so the flag settles
    // in the same edge that stores the sample.
    dopc_alu u_dopc_alu (
        .mode     (state_ff.mode),
        .mism_sel (state_ff.mism),
        .ref_val  (state_ff.ref_val),
        .in_val   (pwdata[15:0]),
        .cond     (alu_cond),
        .result   (alu_result)
    );

    // No access takes a wait state: pready rises in the first access cycle.
    assign setup_w = psel && !penable;
    assign wr_w    = psel && penable && state_ff.ready && pwrite;
    assign in_wr_w = wr_w && (paddr == dopc_pkg::ADDR_INPUT);

    // Address decode shared by the error answer and the checks below.
    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == dopc_pkg::ADDR_CTRL) || (a == dopc_pkg::ADDR_REF) ||
                     (a == dopc_pkg::ADDR_INPUT) || (a == dopc_pkg::ADDR_STATUS);
    endfunction : known_addr

    // Next-state logic for registers, flag and bus answer.
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.ready  = setup_w;
        nxt_state.slverr = setup_w && !known_addr(paddr);
        nxt_state.rdata  = 32'h0000_0000;
        // Read data are picked in the setup cycle and registered, so prdata comes
        // from a flip-flop in the access cycle; between transfers it reads zero.
        if (setup_w && !pwrite) begin
            unique case (paddr)
                dopc_pkg::ADDR_CTRL:   nxt_state.rdata = {28'h0, 1'b0, state_ff.mism,
                                                          state_ff.mode};
                dopc_pkg::ADDR_REF:    nxt_state.rdata = {16'h0, state_ff.ref_val};
                dopc_pkg::ADDR_INPUT:  nxt_state.rdata = {16'h0, state_ff.in_val};
                dopc_pkg::ADDR_STATUS: nxt_state.rdata = {31'h0, state_ff.flag};
                default:               nxt_state.rdata = 32'h0000_0000;
            endcase
        end
        // Control write; the clear bit is a strobe and is not stored.
        if (wr_w && paddr == dopc_pkg::ADDR_CTRL) begin
            nxt_state.mode = pwdata[dopc_pkg::CTRL_MODE_LSB +: 2];
            nxt_state.mism = pwdata[dopc_pkg::CTRL_MISM_BIT];
            if (pwdata[dopc_pkg::CTRL_CLR_BIT]) begin
                nxt_state.flag = 1'b0;
            end
        end
        // Threshold load from the host.
        if (wr_w && paddr == dopc_pkg::ADDR_REF) begin
            nxt_state.ref_val = pwdata[15:0];
        end
        // A sample write stores the input and runs the selected operation.
        if (in_wr_w) begin
            nxt_state.in_val = pwdata[15:0];
            if (state_ff.mode == dopc_pkg::DOPC_MODE_SUB ||
                state_ff.mode == dopc_pkg::DOPC_MODE_ADD) begin
                nxt_state.ref_val = alu_result;
            end
            // Setting wins over a clear landing in the same cycle.
            if (alu_cond) begin
                nxt_state.flag = 1'b1;
            end
        end
        // Request tracks the sticky flag so it holds until software clears it.
        nxt_state.irq = nxt_state.flag;
    end

    // Single state register with synchronous reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Clearing the whole struct first keeps the bus answer and the flag
            // quiet during reset; the named fields then take their reset values.
            state_ff         <= '0;
            state_ff.mode    <= dopc_pkg::MODE_RESET;
            state_ff.ref_val <= dopc_pkg::REF_RESET;
            state_ff.in_val  <= dopc_pkg::INPUT_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Every output comes straight from the state register.
    assign prdata  = state_ff.rdata;
    assign pready  = state_ff.ready;
    assign pslverr = state_ff.slverr;
    assign op_irq  = state_ff.irq;

    // Checks on the datapath and flag behaviour. Expected values are worked out
    // from the operands here rather than read from the arithmetic core, so a slip
    // in the core's carry or borrow logic shows up as a failing check.
    chk_sub_underflow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_SUB &&
        pwdata[15:0] > state_ff.ref_val |=> state_ff.flag)
        else $error("underflow did not set flag");
    chk_sub_writeback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_SUB |=>
        state_ff.ref_val == $past(state_ff.ref_val) - $past(pwdata[15:0]))
        else $error("difference not written back");
    chk_add_writeback: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_ADD |=>
        state_ff.ref_val == $past(state_ff.ref_val) + $past(pwdata[15:0]))
        else $error("sum not written back");
    chk_add_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_ADD &&
        ({1'b0, pwdata[15:0]} + {1'b0, state_ff.ref_val}) > 17'h0ffff
        |=> state_ff.flag)
        else $error("carry did not set flag");
    chk_cmp_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_CMP && !state_ff.flag &&
        !((pwdata[15:0] == state_ff.ref_val) ^ state_ff.mism) |=> !state_ff.flag)
        else $error("compare flagged wrongly");
    chk_cmp_keeps_ref: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_CMP |=>
        state_ff.ref_val == $past(state_ff.ref_val))
        else $error("compare altered reference");
    chk_bad_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == 2'h3 |=> state_ff.ref_val == $past(state_ff.ref_val))
        else $error("illegal mode altered reference");
    chk_bad_mode_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == 2'h3 && !state_ff.flag |=> !state_ff.flag)
        else $error("illegal mode raised flag");
    chk_sub_code: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == 2'h2 && pwdata[15:0] <= state_ff.ref_val &&
        !state_ff.flag |=> !state_ff.flag)
        else $error("no-borrow subtraction flagged");

    // Flag and request.
    chk_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_ff.flag && !(wr_w && paddr == dopc_pkg::ADDR_CTRL &&
        pwdata[dopc_pkg::CTRL_CLR_BIT]) |=> state_ff.flag)
        else $error("flag dropped without clear");
    chk_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state_ff.flag) |-> $past(in_wr_w) && $past(alu_cond))
        else $error("flag rose without cause");
    chk_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_w && paddr == dopc_pkg::ADDR_CTRL && pwdata[dopc_pkg::CTRL_CLR_BIT] |=>
        !state_ff.flag)
        else $error("clear did not drop flag");
    chk_irq_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !state_ff.flag && !(in_wr_w && alu_cond) |=> !op_irq)
        else $error("request raised without a condition");
    chk_irq_on_cond: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && alu_cond |=> op_irq)
        else $error("condition did not raise request");

    // Register bus: no wait state, a one-cycle answer, an error only for map holes.
    chk_ref_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_w && paddr == dopc_pkg::ADDR_REF |=> state_ff.ref_val == $past(pwdata[15:0]))
        else $error("reference write lost");
    chk_input_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w |=> state_ff.in_val == $past(pwdata[15:0]))
        else $error("input write lost");
    chk_ready_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup_w |=> pready)
        else $error("no ready in access cycle");
    chk_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pready |=> !pready)
        else $error("ready stood longer than one cycle");
    chk_err_unmapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup_w && !known_addr(paddr) |=> pready && pslverr)
        else $error("unmapped access not refused");
    chk_err_mapped: assert property (@(posedge ref_clk) disable iff (!rst_n)
        setup_w && known_addr(paddr) |=> !pslverr)
        else $error("mapped access refused");
    chk_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access cycle");

    // Main scenarios that a run should reach.
    cov_sub_flag: cover property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_SUB ##1 $rose(state_ff.flag));
    cov_add_flag: cover property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_ADD ##1 $rose(state_ff.flag));
    cov_cmp_flag: cover property (@(posedge ref_clk) disable iff (!rst_n)
        in_wr_w && state_ff.mode == dopc_pkg::DOPC_MODE_CMP ##1 $rose(state_ff.flag));
    cov_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(state_ff.flag));
    cov_unmapped: cover property (@(posedge ref_clk) disable iff (!rst_n) pready && pslverr);
endmodule : dopc_top

/* testbench/dopc_host.sv */
// Processor-side model that loads operands over the register bus.
`timescale 1ns/1ps
module dopc_host (
    input  wire logic        ref_clk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata
);
    // The bus starts idle so no transfer is seen during reset.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
    end

    // Setup cycle, then the access is held until pready is sampled high.
    task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdata = prdata;
        err   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data is inverted so a stale value cannot pass for a new one.
        pwdata  <= ~wdata;
    endtask : xfer
endmodule : dopc_host

/* testbench/test_dopc_top.sv */
// Self-checking testbench of the data operation circuit.
`timescale 1ns/1ps
module test_dopc_top;
    typedef struct packed {
        logic [1:0]  mode;
        logic        mism;
        logic [15:0] rv;
        logic [15:0] iv;
        logic        flag;
        logic [15:0] res;
    } dopc_case_t;
    logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, op_irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          error_cnt = 0;
    int          n_tests = 0;
    dopc_case_t  tc [10] = '{
        '{2'h2, 1'b0, 16'h0200, 16'h0150, 1'b0, 16'h00b0}, '{2'h2, 1'b0, 16'h0200, 16'h0250, 1'b1, 16'hffb0},
        '{2'h2, 1'b0, 16'h0000, 16'h0000, 1'b0, 16'h0000}, '{2'h1, 1'b0, 16'hffff, 16'h0001, 1'b1, 16'h0000},
        '{2'h1, 1'b0, 16'hfffe, 16'h0001, 1'b0, 16'hffff}, '{2'h0, 1'b0, 16'h5a5a, 16'h5a5a, 1'b1, 16'h5a5a},
        '{2'h0, 1'b0, 16'h5a5a, 16'h5a5b, 1'b0, 16'h5a5a}, '{2'h0, 1'b1, 16'h5a5a, 16'h5a5a, 1'b0, 16'h5a5a},
        '{2'h0, 1'b1, 16'h5a5a, 16'h0000, 1'b1, 16'h5a5a}, '{2'h3, 1'b0, 16'h0001, 16'h0002, 1'b0, 16'h0001}};

    dopc_top u_dopc_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_irq(op_irq));
    dopc_host u_dopc_host (.ref_clk(ref_clk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata));

    // Free-running 250 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask : check

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Register access helpers; the error response is checked on every transfer.
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        u_dopc_host.xfer(1'b1, a, d, rd, er);
        check("pslverr", {31'h0, e}, {31'h0, er});
    endtask : wr
    task automatic rc(input string w, input logic [11:0] a, input logic [31:0] x, input logic e);
        u_dopc_host.xfer(1'b0, a, 32'h0000_0000, rd, er);
        check(w, x, rd);
        check("pslverr", {31'h0, e}, {31'h0, er});
    endtask : rc

    // Watchdog well beyond the hundred or so transfers of the run.
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        test_done();
    end

    // Reset values, unmapped access, then every mode and condition from the table.
    initial begin
        rst_n = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        rc("ctrl", dopc_pkg::ADDR_CTRL, 32'h0, 1'b0);
        rc("ref", dopc_pkg::ADDR_REF, {16'h0, dopc_pkg::REF_RESET}, 1'b0);
        rc("input", dopc_pkg::ADDR_INPUT, {16'h0, dopc_pkg::INPUT_RESET}, 1'b0);
        rc("status", dopc_pkg::ADDR_STATUS, 32'h0, 1'b0);
        wr(12'h010, 32'hffff_ffff, 1'b1);
        rc("unmapped", 12'h010, 32'h0, 1'b1);
        foreach (tc[i]) begin
            wr(dopc_pkg::ADDR_CTRL, {28'h0, 1'b1, tc[i].mism, tc[i].mode}, 1'b0);
            rc("ctrl", dopc_pkg::ADDR_CTRL, {29'h0, tc[i].mism, tc[i].mode}, 1'b0);
            rc("cleared", dopc_pkg::ADDR_STATUS, 32'h0, 1'b0);
            check("irq_clr", 32'h0, {31'h0, op_irq});
            wr(dopc_pkg::ADDR_REF, {16'hffff, tc[i].rv}, 1'b0);
            wr(dopc_pkg::ADDR_INPUT, {16'hffff, tc[i].iv}, 1'b0);
            rc("ref", dopc_pkg::ADDR_REF, {16'h0, tc[i].res}, 1'b0);
            rc("input", dopc_pkg::ADDR_INPUT, {16'h0, tc[i].iv}, 1'b0);
            rc("flag", dopc_pkg::ADDR_STATUS, {31'h0, tc[i].flag}, 1'b0);
            check("irq", {31'h0, tc[i].flag}, {31'h0, op_irq});
            if (tc[i].flag) begin
                wr(dopc_pkg::ADDR_INPUT, 32'h0, 1'b0);
                rc("sticky", dopc_pkg::ADDR_STATUS, 32'h1, 1'b0);
            end
        end
        // Reset in mid-run with the flag set must clear flag, request and registers.
        wr(dopc_pkg::ADDR_CTRL, {30'h0, dopc_pkg::DOPC_MODE_SUB}, 1'b0);
        wr(dopc_pkg::ADDR_REF, 32'h0000_0000, 1'b0);
        wr(dopc_pkg::ADDR_INPUT, 32'h0000_0001, 1'b0);
        rc("flag_set", dopc_pkg::ADDR_STATUS, 32'h1, 1'b0);
        check("irq_set", 32'h1, {31'h0, op_irq});
        rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        check("irq_rst", 32'h0, {31'h0, op_irq});
        rc("status_rst", dopc_pkg::ADDR_STATUS, 32'h0, 1'b0);
        rc("ref_rst", dopc_pkg::ADDR_REF, {16'h0, dopc_pkg::REF_RESET}, 1'b0);
        rc("ctrl_rst", dopc_pkg::ADDR_CTRL, 32'h0, 1'b0);
        test_done();
    end
endmodule : test_dopc_top
